// [src/wdt_top.sv]
/*
 * Watchdog timeout block: counts a selectable period and on expiry requests a
 * chip reset or raises an exception strobe, with a retained cause flag.
 * Assumes CLK_SYS is the clock derived from the internal RC oscillator, that
 * RST_N is the warm chip reset that this block's request drives, and that
 * COLD_RST_N is the power-on reset. Commands come from logic on CLK_SYS.
 */
`timescale 1ns/1ns

module wdt_top
	import wdt_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = 32'(`WDT_TICK_CYC)
) (
	// Clock and resets.
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic COLD_RST_N,
	// Software commands, one-cycle pulses.
	input wire logic RESTART_COMMAND,
	input wire logic STOP_COMMAND,
	input wire logic TIMEOUT_SET_START_COMMAND,
	input wire logic [`WDT_IDX_W-1:0] TIMEOUT_SEL,
	input wire logic FLAG_CLEAR_COMMAND,
	// Configuration level.
	input wire logic EXCEPTION_MODE_ENABLE,
	// Power and debug state.
	input wire logic SLEEP_MODE,
	input wire logic WAKE_EVENT,
	input wire logic DEBUG_HALT,
	// Flash access in progress.
	input wire logic FLASH_BUSY,
	// Expiry actions.
	output logic CHIP_RST_REQ,
	output logic EXC_STROBE,
	output logic PROG_MODE_REQ,
	// Status.
	output logic EXPIRY_CAUSE_FLAG,
	output logic [`WDT_READ_W-1:0] COUNT_READBACK,
	output logic WDT_RUNNING,
	output logic [`WDT_IDX_W-1:0] TIMEOUT_IDX
);

	wdt_state_t state;
	wdt_idx_t idx;
	wdt_cnt_t count;
	wdt_cnt_t term;
	logic dbg_halt;
	logic paused;
	logic counting;
	logic tick;
	logic expire;
	logic restart_ok;
	logic set_ok;
	logic start_from_stop;
	logic div_clr;
	logic rst_q;
	logic rst_release;

	// The debugger halt comes from another domain and is synchronised first.
	wdt_sync2 u_dbg_sync (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.d(DEBUG_HALT),
		.q(dbg_halt)
	);

	// Doze is not an input at all, so it never slows the count.
	assign paused = SLEEP_MODE || dbg_halt;
	assign counting = (state == WDT_RUN) && !paused;

	// Commands that are ignored after a reset-mode expiry or when stop arrives too.
	assign restart_ok = RESTART_COMMAND && !STOP_COMMAND && (state != WDT_FIRED);
	assign set_ok = TIMEOUT_SET_START_COMMAND && !STOP_COMMAND && (state != WDT_FIRED);
	assign start_from_stop = set_ok && (state == WDT_STOP);

	// A fresh period starts on a tick boundary, so the divider phase clears too.
	assign div_clr = restart_ok || start_from_stop || expire || WAKE_EVENT;

	// Base tick of 8 ms derived from the oscillator clock.
	wdt_tick_div #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.en(counting),
		.clr(div_clr),
		.tick(tick)
	);

	// Terminal tick count of the selected period.
	assign term = wdt_term(idx);

	// A shortened period may already be passed, so the compare is not exact.
	assign expire = counting && tick && (count >= 12'(term - 12'h001));

	// Operating state; a wake wins over stop, and stop wins over every other command in the same cycle.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || WAKE_EVENT) begin
			state <= WDT_RUN;
		end else begin
			case (state)
				WDT_RUN: begin
					if (STOP_COMMAND) begin
						state <= WDT_STOP;
					end else if (expire && !EXCEPTION_MODE_ENABLE) begin
						state <= WDT_FIRED;
					end else begin
						state <= WDT_RUN;
					end
				end
				WDT_STOP: begin
					if (set_ok) begin
						state <= WDT_RUN;
					end else begin
						state <= WDT_STOP;
					end
				end
				WDT_FIRED: begin
					state <= WDT_FIRED;
				end
				default: begin
					state <= WDT_RUN;
				end
			endcase
		end
	end

	// Timeout select; an index above the top is held at the top.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || WAKE_EVENT) begin
			idx <= `WDT_IDX_MAX;
		end else if (set_ok) begin
			idx <= (TIMEOUT_SEL > `WDT_IDX_MAX) ? `WDT_IDX_MAX : TIMEOUT_SEL;
		end
	end

	// Tick counter; a retime of a running timer keeps the count reached.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || WAKE_EVENT) begin
			count <= `WDT_CNT_RST;
		end else if (STOP_COMMAND) begin
			count <= count;
		end else if (restart_ok || start_from_stop) begin
			count <= `WDT_CNT_RST;
		end else if (expire) begin
			count <= `WDT_CNT_RST;
		end else if (tick) begin
			count <= 12'(count + 12'h001);
		end
	end

	// Delayed copy of the warm reset, used to find its release.
	always_ff @(posedge CLK_SYS) begin
		if (!COLD_RST_N) begin
			rst_q <= 1'b0;
		end else begin
			rst_q <= RST_N;
		end
	end
	assign rst_release = RST_N && !rst_q;

	// The reset request lives on the cold reset so it stands through the warm one.
	always_ff @(posedge CLK_SYS) begin
		if (!COLD_RST_N) begin
			CHIP_RST_REQ <= 1'b0;
		end else if (expire && !EXCEPTION_MODE_ENABLE) begin
			CHIP_RST_REQ <= 1'b1;
		end else if (rst_release) begin
			CHIP_RST_REQ <= 1'b0;
		end
	end

	// Exception strobe for the stack-overflow handler, one cycle per expiry.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			EXC_STROBE <= 1'b0;
		end else begin
			EXC_STROBE <= expire && EXCEPTION_MODE_ENABLE;
		end
	end

	// Cause flag: during a warm reset it records whether this block asked for it.
	// It clears on software request, but a new exception expiry in that cycle wins.
	always_ff @(posedge CLK_SYS) begin
		if (!COLD_RST_N) begin
			EXPIRY_CAUSE_FLAG <= 1'b0;
		end else if (!RST_N) begin
			EXPIRY_CAUSE_FLAG <= CHIP_RST_REQ;
		end else if (expire) begin
			EXPIRY_CAUSE_FLAG <= 1'b1;
		end else if (FLAG_CLEAR_COMMAND) begin
			EXPIRY_CAUSE_FLAG <= 1'b0;
		end
	end

	// Programming-mode request survives the warm reset; only power-on clears it.
	always_ff @(posedge CLK_SYS) begin
		if (!COLD_RST_N) begin
			PROG_MODE_REQ <= 1'b0;
		end else if (expire && !EXCEPTION_MODE_ENABLE && FLASH_BUSY) begin
			PROG_MODE_REQ <= 1'b1;
		end
	end

	// Status outputs straight from the state flops.
	assign COUNT_READBACK = {{(`WDT_READ_W - `WDT_CNT_W){1'b0}}, count};
	assign WDT_RUNNING = (state == WDT_RUN);
	assign TIMEOUT_IDX = idx;

	// Checks of the timing and command behaviour.
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N || !COLD_RST_N);
	// A check that a warm reset cuts short is dropped, so retention is compared outside.

	// Expiry that asks for a chip reset.
	sequence reset_exp_s;
		expire && !EXCEPTION_MODE_ENABLE;
	endsequence

	// The request stands at least three cycles, long enough for the reset logic to see it.
	sequence req_held_s;
		CHIP_RST_REQ [*3];
	endsequence

	// Expiry that asks for the exception instead of a reset.
	sequence exc_exp_s;
		expire && EXCEPTION_MODE_ENABLE;
	endsequence

	// A single pulse, so the handler sees exactly one event per expiry.
	sequence exc_seen_s;
		EXC_STROBE && !CHIP_RST_REQ ##1 !EXC_STROBE;
	endsequence

	// No command that may legitimately move the count or the tick phase.
	sequence quiet_s;
		!RESTART_COMMAND && !TIMEOUT_SET_START_COMMAND && !WAKE_EVENT;
	endsequence

	reset_request_a: assert property (reset_exp_s |=> req_held_s)
		else $error("reset request not held after expiry");

	exc_strobe_a: assert property (exc_exp_s and !CHIP_RST_REQ |=> exc_seen_s)
		else $error("exception expiry did not give one strobe");

	reset_max_a: assert property ($rose(RST_N) |->
		state == WDT_RUN && idx == `WDT_IDX_MAX && count == `WDT_CNT_RST)
		else $error("watchdog not running at longest period after reset");

	pause_hold_a: assert property (paused and quiet_s |=>
		$stable(count) && $stable(u_tick.phase))
		else $error("count moved while paused");

	restart_zero_a: assert property (restart_ok && !set_ok && !WAKE_EVENT |=>
		count == `WDT_CNT_RST && $stable(idx))
		else $error("restart did not return to period start");

	set_start_a: assert property (start_from_stop && TIMEOUT_SEL <= `WDT_IDX_MAX |=>
		WDT_RUNNING && idx == $past(TIMEOUT_SEL) && count == `WDT_CNT_RST)
		else $error("select while stopped did not start");

	stop_freeze_a: assert property (state == WDT_STOP and quiet_s |=>
		$stable(count) && !EXC_STROBE && !$rose(CHIP_RST_REQ))
		else $error("stopped watchdog changed or acted");

	readback_a: assert property (COUNT_READBACK[`WDT_CNT_W-1:0] == count &&
		COUNT_READBACK[`WDT_READ_W-1:`WDT_CNT_W] == '0)
		else $error("readback differs from count");

	cause_flag_a: assert property (expire |=> EXPIRY_CAUSE_FLAG)
		else $error("cause flag not set by expiry");

	prog_mode_a: assert property (reset_exp_s and FLASH_BUSY |=> PROG_MODE_REQ [*2])
		else $error("flash-busy expiry did not request programming mode");

	terminal_a: assert property (counting && tick && !STOP_COMMAND &&
		count == 12'(term - 12'h001) |-> expire ##1 count == `WDT_CNT_RST)
		else $error("no expiry at terminal count");

	period_one_a: assert property (idx == 4'h0 |-> term == 12'h001)
		else $error("select zero is not one tick");

	// A wake reloads the power-up state, whatever the earlier state was.
	wake_reload_a: assert property (WAKE_EVENT |=>
		state == WDT_RUN && idx == `WDT_IDX_MAX && count == `WDT_CNT_RST)
		else $error("wake did not reload the longest period");

	// After a reset-mode expiry only a reset or a wake may move the block.
	fired_hold_a: assert property (state == WDT_FIRED && !WAKE_EVENT |=>
		state == WDT_FIRED && $stable(count))
		else $error("fired watchdog left its halted state");

	// An exception expiry leaves the watchdog running a fresh period.
	exc_run_a: assert property (exc_exp_s and !STOP_COMMAND |=>
		WDT_RUNNING && count == `WDT_CNT_RST)
		else $error("exception expiry did not restart the period");

	// Stop is taken in any live state and holds the count reached.
	stop_cmd_a: assert property (STOP_COMMAND && !WAKE_EVENT && state != WDT_FIRED |=>
		state == WDT_STOP && $stable(count))
		else $error("stop did not freeze the watchdog");

	// The request stands until the warm reset that it asked for is released.
	req_stand_a: assert property (CHIP_RST_REQ && !rst_release |=> CHIP_RST_REQ)
		else $error("reset request dropped before reset release");

endmodule : wdt_top

// [include/wdt_defines.svh]
/*
 * Constants of the watchdog timeout block: timing, select range and widths.
 * Assumes it is included once per compilation unit by its bare name.
 */
// Summary of operation
// - Expiry at the selected period requests a whole-chip reset unless exception mode is set.
// - The count runs from the RC-oscillator clock, nominally 27 or 32 MHz.
// - Power-up, any reset or wake-up leaves the watchdog running at the longest period.
// - Select 0 gives 8 ms; select p of 1 to 12 gives (2^(p-1)+1) x 8 ms.
// - Counting goes on in doze, pauses in sleep and debugger halt, then resumes.
// - Restart returns the count to period start and keeps the selected period.
// - Selecting a period starts a stopped watchdog, or retimes a running one.
// - Stop freezes the count and no expiry acts while stopped.
// - Software can read the current count at any time.
// - A cause flag survives the chip reset and tells a watchdog reset apart.
// - Reset is the default expiry action; exception mode raises the overflow exception.
// - After an exception expiry the cause flag shows a watchdog event occurred.
// - A reset-mode expiry during a flash access sends the chip into programming mode; an exception-mode expiry does not.
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// Oscillator and system clock rates in Hz.
`define WDT_RC_HZ_LO 27000000
`define WDT_RC_HZ_HI 32000000
`define WDT_CLK_HZ 100000000

// Base period of one tick in milliseconds and its length in clock cycles.
`define WDT_BASE_MS 8
`define WDT_TICK_CYC ((64'(`WDT_BASE_MS) * 64'(`WDT_CLK_HZ)) / 64'd1000)

// Timeout select field and counter widths.
`define WDT_IDX_W 4
`define WDT_IDX_MAX 4'hC
`define WDT_CNT_W 12
`define WDT_READ_W 16

// Reset values.
`define WDT_CNT_RST 12'h000

`endif

// [include/wdt_pkg.sv]
/*
 * Types and the terminal-count decode of the watchdog timeout block.
 * Assumes the defines header is on the include path.
 */
`include "wdt_defines.svh"

package wdt_pkg;

	// Watchdog operating state, one-hot.
	typedef enum logic [2:0] {
		WDT_RUN = 3'h1,
		WDT_STOP = 3'h2,
		WDT_FIRED = 3'h4
	} wdt_state_t;

	typedef logic [`WDT_IDX_W-1:0] wdt_idx_t;
	typedef logic [`WDT_CNT_W-1:0] wdt_cnt_t;

	// Number of base ticks in the period of a select index; out-of-range reads as the top.
	function automatic wdt_cnt_t wdt_term(input wdt_idx_t idx);
		wdt_idx_t p;
		p = (idx > `WDT_IDX_MAX) ? `WDT_IDX_MAX : idx;
		if (p == 4'h0) begin
			wdt_term = 12'h001;
		end else begin
			wdt_term = 12'((12'h001 << (p - 4'h1)) + 12'h001);
		end
	endfunction : wdt_term

endpackage : wdt_pkg

// [src/wdt_sync2.sv]
/*
 * Two-flop level synchroniser for a signal from another clock domain.
 * Assumes the input is a slow level; pulses shorter than two cycles may vanish.
 */
`timescale 1ns/1ns

module wdt_sync2 (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Level in and out.
	input wire logic d,
	output logic q
);

	logic meta;

	// Only the second flop reads the first, to keep metastability contained.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta <= 1'b0;
			q <= 1'b0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end

endmodule : wdt_sync2

// [src/wdt_tick_div.sv]
/*
 * Divider that makes the one-cycle base tick of the watchdog.
 * Assumes en freezes the phase and clr returns it to the start of a tick.
 */
`timescale 1ns/1ns

module wdt_tick_div #(
	parameter int unsigned CYCLES = 800000
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Control.
	input wire logic en,
	input wire logic clr,
	// One-cycle tick.
	output logic tick
);

	localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] phase;

	// The tick fires on the last phase only while counting is allowed.
	assign tick = en && (phase == LAST);

	// Phase counter; it holds when disabled so a pause loses no time.
	always_ff @(posedge clk) begin
		if (!rst_n || clr) begin
			phase <= '0;
		end else if (tick) begin
			phase <= '0;
		end else if (en) begin
			phase <= W'(phase + 1'b1);
		end
	end

endmodule : wdt_tick_div

// [tb/tb_top.sv]
/*
 * Self-checking bench of the watchdog timeout block: command pulses, expiry timing,
 * pause, reset retention and programming-mode request. Assumes the design's own
 * assertions watch its internals and that a tick of four cycles keeps runs short.
 */
`timescale 1ns/1ns
`include "wdt_defines.svh"

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("ERROR at %0t: got %0h expected %0h", $time, got, exp); end end

module tb_top;
	logic CLK_SYS = 1'b0;
	logic RST_N = 1'b0;
	logic COLD_RST_N = 1'b0;
	logic RESTART_COMMAND = 1'b0;
	logic STOP_COMMAND = 1'b0;
	logic TIMEOUT_SET_START_COMMAND = 1'b0;
	logic [`WDT_IDX_W-1:0] TIMEOUT_SEL = 4'h0;
	logic FLAG_CLEAR_COMMAND = 1'b0;
	logic EXCEPTION_MODE_ENABLE = 1'b0;
	logic SLEEP_MODE = 1'b0;
	logic WAKE_EVENT = 1'b0;
	logic DEBUG_HALT = 1'b0;
	logic FLASH_BUSY = 1'b0;
	logic CHIP_RST_REQ, EXC_STROBE, PROG_MODE_REQ, EXPIRY_CAUSE_FLAG, WDT_RUNNING;
	logic [`WDT_READ_W-1:0] COUNT_READBACK;
	logic [`WDT_IDX_W-1:0] TIMEOUT_IDX;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_strobe = 0;
	int n;
	int k;

	wdt_top #(.TICK_CYCLES(4)) wdt_top_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
		.COLD_RST_N(COLD_RST_N), .RESTART_COMMAND(RESTART_COMMAND),
		.STOP_COMMAND(STOP_COMMAND), .TIMEOUT_SET_START_COMMAND(TIMEOUT_SET_START_COMMAND),
		.TIMEOUT_SEL(TIMEOUT_SEL), .FLAG_CLEAR_COMMAND(FLAG_CLEAR_COMMAND),
		.EXCEPTION_MODE_ENABLE(EXCEPTION_MODE_ENABLE), .SLEEP_MODE(SLEEP_MODE),
		.WAKE_EVENT(WAKE_EVENT), .DEBUG_HALT(DEBUG_HALT), .FLASH_BUSY(FLASH_BUSY),
		.CHIP_RST_REQ(CHIP_RST_REQ), .EXC_STROBE(EXC_STROBE), .PROG_MODE_REQ(PROG_MODE_REQ),
		.EXPIRY_CAUSE_FLAG(EXPIRY_CAUSE_FLAG), .COUNT_READBACK(COUNT_READBACK),
		.WDT_RUNNING(WDT_RUNNING), .TIMEOUT_IDX(TIMEOUT_IDX));

	// A 100 MHz clock, inverted every half period.
	always #5 CLK_SYS = ~CLK_SYS;

	// Exception strobes are counted so that a missed or extra one shows later.
	always @(posedge CLK_SYS) begin
		if (EXC_STROBE === 1'b1) begin
			n_strobe <= n_strobe + 1;
		end
	end

	// One command cycle, driven at the falling edge; taken at the rising edge between.
	task cmd(input logic rs, input logic st, input logic se, input logic [3:0] sel);
		@(negedge CLK_SYS);
		RESTART_COMMAND = rs;
		STOP_COMMAND = st;
		TIMEOUT_SET_START_COMMAND = se;
		TIMEOUT_SEL = sel;
		@(negedge CLK_SYS);
		RESTART_COMMAND = 1'b0;
		STOP_COMMAND = 1'b0;
		TIMEOUT_SET_START_COMMAND = 1'b0;
	endtask : cmd

	// Restarts with select p, pauses by sleep for s edges, counts edges to expiry.
	task measure(input logic [3:0] p, input int s, output int cnt);
		cmd(1'b1, 1'b0, 1'b1, p);
		cnt = 0;
		while (cnt < 40000) begin
			@(posedge CLK_SYS);
			cnt++;
			#1;
			if (p == 4'h3 && s == 0 && cnt == 11) `CHK(COUNT_READBACK, 16'h0002)
			if (EXC_STROBE === 1'b1 || CHIP_RST_REQ === 1'b1) break;
			@(negedge CLK_SYS);
			SLEEP_MODE = (cnt <= s);
		end
		SLEEP_MODE = 1'b0;
	endtask : measure

	// Warm reset held three cycles, returning one edge after release.
	task warm_reset;
		@(negedge CLK_SYS);
		RST_N = 1'b0;
		repeat (3) @(negedge CLK_SYS);
		RST_N = 1'b1;
		@(negedge CLK_SYS);
	endtask : warm_reset

	// Prints the tallies and the verdict, then ends the run.
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test

	// A hang is cut short well after the longest expected run.
	initial begin
		#600000;
		n_mismatch++;
		finish_test();
	end

	// Main sequence.
	initial begin
		repeat (5) @(negedge CLK_SYS);
		RST_N = 1'b1;
		COLD_RST_N = 1'b1;
		@(negedge CLK_SYS);
		`CHK(WDT_RUNNING, 1'b1)
		`CHK(TIMEOUT_IDX, 4'hC)
		`CHK(EXPIRY_CAUSE_FLAG, 1'b0)
		// A plain restart, then stop freezes the count partway through a period.
		cmd(1'b1, 1'b0, 1'b0, 4'hC);
		repeat (8) @(negedge CLK_SYS);
		cmd(1'b0, 1'b1, 1'b0, 4'h0);
		`CHK(WDT_RUNNING, 1'b0)
		repeat (50) @(negedge CLK_SYS);
		`CHK(COUNT_READBACK, 16'h0002)
		`CHK(n_strobe, 0)
		cmd(1'b0, 1'b0, 1'b1, 4'h0);
		`CHK(WDT_RUNNING, 1'b1)
		`CHK(TIMEOUT_IDX, 4'h0)
		cmd(1'b0, 1'b1, 1'b0, 4'h0);
		repeat (20) @(negedge CLK_SYS);
		`CHK(CHIP_RST_REQ, 1'b0)
		// Wake reloads the longest period whatever the state was.
		WAKE_EVENT = 1'b1;
		@(negedge CLK_SYS);
		WAKE_EVENT = 1'b0;
		`CHK(WDT_RUNNING, 1'b1)
		`CHK(TIMEOUT_IDX, 4'hC)
		// Selecting while running keeps it running; a select above the top is clamped.
		cmd(1'b0, 1'b0, 1'b1, 4'hF);
		`CHK(TIMEOUT_IDX, 4'hC)
		cmd(1'b0, 1'b0, 1'b1, 4'h5);
		`CHK(WDT_RUNNING, 1'b1)
		`CHK(TIMEOUT_IDX, 4'h5)
		// Every select index, timed to the exception strobe.
		EXCEPTION_MODE_ENABLE = 1'b1;
		for (k = 0; k <= 12; k++) begin
			measure(4'(k), 0, n);
			`CHK(n, (k == 0) ? 4 : 4 * ((1 << (k - 1)) + 1))
		end
		repeat (2) @(negedge CLK_SYS);
		`CHK(n_strobe, 13)
		`CHK(CHIP_RST_REQ, 1'b0)
		`CHK(EXPIRY_CAUSE_FLAG, 1'b1)
		`CHK(WDT_RUNNING, 1'b1)
		FLAG_CLEAR_COMMAND = 1'b1;
		@(negedge CLK_SYS);
		FLAG_CLEAR_COMMAND = 1'b0;
		`CHK(EXPIRY_CAUSE_FLAG, 1'b0)
		// Sleep delays expiry by exactly the paused edges.
		measure(4'h1, 10, n);
		`CHK(n, 18)
		// Debug halt holds off expiry until released.
		cmd(1'b1, 1'b0, 1'b1, 4'h1);
		DEBUG_HALT = 1'b1;
		k = n_strobe;
		repeat (40) @(negedge CLK_SYS);
		`CHK(n_strobe, k)
		`CHK(COUNT_READBACK, 16'h0000)
		DEBUG_HALT = 1'b0;
		repeat (12) @(negedge CLK_SYS);
		`CHK(n_strobe, k + 1)
		// Reset-mode expiry, refusal while fired, and the retained cause.
		EXCEPTION_MODE_ENABLE = 1'b0;
		measure(4'h0, 0, n);
		`CHK(n, 4)
		@(negedge CLK_SYS);
		`CHK(EXC_STROBE, 1'b0)
		`CHK(EXPIRY_CAUSE_FLAG, 1'b1)
		`CHK(PROG_MODE_REQ, 1'b0)
		cmd(1'b1, 1'b0, 1'b1, 4'h5);
		`CHK(WDT_RUNNING, 1'b0)
		`CHK(CHIP_RST_REQ, 1'b1)
		warm_reset();
		`CHK(CHIP_RST_REQ, 1'b0)
		`CHK(EXPIRY_CAUSE_FLAG, 1'b1)
		`CHK(TIMEOUT_IDX, 4'hC)
		`CHK(WDT_RUNNING, 1'b1)
		warm_reset();
		`CHK(EXPIRY_CAUSE_FLAG, 1'b0)
		// Expiry during a flash access asks for programming mode.
		FLASH_BUSY = 1'b1;
		measure(4'h0, 0, n);
		@(negedge CLK_SYS);
		`CHK(PROG_MODE_REQ, 1'b1)
		FLASH_BUSY = 1'b0;
		warm_reset();
		`CHK(PROG_MODE_REQ, 1'b1)
		finish_test();
	end
endmodule : tb_top
